// ---- hdl/gor_pkg.sv ----
// Package with register map, field layout, reset values and timing counts for the rate block
//Behaviour
//R1: Y offset in two byte registers, read/write
//R2: Z offset in two byte registers, read/write
//R3: Offset added to raw rate before output
//R4: Output rate is 1 kHz over divider+1
//R5: Rate strobe updates outputs and queue writes
//R6: Divider used only unbypassed with setting 1-6
//R7: Config bit 7 resets to one
//R8: Policy one: full queue drops new samples
//R9: Policy zero: full queue overwrites oldest entry
//R10: Placement field picks frame-sync destination bit
//R11: Frame-sync edge latched once until captured
//R12: Low-pass applied only when bypass bits zero
//R13: Internal rate 32k, 8k or 1k
//R14: Setting selects documented 3-dB bandwidth figure
//R15: Bypass bits sit in rate config bits 1:0
//R16: Offset applied only after both bytes written
package gor_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_Y_OFS_HI = 8'h15;
    localparam logic [7:0] IDX_Y_OFS_LO = 8'h16;
    localparam logic [7:0] IDX_Z_OFS_HI = 8'h17;
    localparam logic [7:0] IDX_Z_OFS_LO = 8'h18;
    localparam logic [7:0] IDX_DIVIDER = 8'h19;
    localparam logic [7:0] IDX_FSQ_CFG = 8'h1a;
    localparam logic [7:0] IDX_RATE_CFG = 8'h1b;
    localparam logic [7:0] IDX_Y_OUT = 8'h20;
    localparam logic [7:0] IDX_Z_OUT = 8'h21;
    localparam logic [7:0] IDX_QUEUE_DATA = 8'h22;
    localparam logic [7:0] IDX_QUEUE_STAT = 8'h23;
    localparam logic [7:0] IDX_BANDWIDTH = 8'h24;
    // Byte address width on the bus
    localparam int ADDR_W = 10;
    // Field positions inside the filter/sync/queue configuration register and the rate configuration register
    localparam int CFG_RSV_BIT = 7;
    localparam int CFG_POLICY_BIT = 6;
    localparam int CFG_PLACE_LSB = 3;
    localparam int CFG_SET_LSB = 0;
    localparam int RCFG_BYP_LSB = 0;
    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h80;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Timing: clock period and internal sample periods in ns
    localparam int CLK_NS = 5;
    localparam int PER_32K_NS = 31250;
    localparam int PER_8K_NS = 125000;
    localparam int PER_1K_NS = 1000000;
    localparam int CYC_32K = PER_32K_NS / CLK_NS;
    localparam int CYC_8K = PER_8K_NS / CLK_NS;
    localparam int CYC_1K = PER_1K_NS / CLK_NS;
    localparam int TICK_W = 18;
    // Queue geometry
    localparam int QDEPTH_LOG = 3;
    localparam int QWIDTH = 32;
    // Placement codes for the frame-sync bit
    localparam logic [2:0] PLACE_OFF = 3'h0;
    localparam logic [2:0] PLACE_Y = 3'h3;
    localparam logic [2:0] PLACE_Z = 3'h4;
    // Rate 3-dB bandwidths in Hz per low-pass setting, plus the bypass modes
    localparam logic [13:0] BW_SET [8] = '{14'h0fa, 14'h0b0, 14'h05c, 14'h029,
                                           14'h014, 14'h00a, 14'h005, 14'h0cd1};
    localparam logic [13:0] BW_BYP0 = 14'h1fed;
    localparam logic [13:0] BW_BYP1 = 14'h0cd1;
    // Bus access phase states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ANSWER = 2'b10
    } gor_bus_type;
endpackage

// ---- hdl/gor_queue_mem.sv ----
// Sample queue storage with registered read data
`timescale 1ns/1ps
module gor_queue_mem (
    mclk, // Clock
    wrEn, // Write strobe
    wrAddr, // Write entry
    wrData, // Write word
    rdAddr, // Read entry
    rdData_q // Registered read word
);
    import gor_pkg::*;
    input wire logic mclk; // Clock
    input wire logic wrEn; // Write strobe
    input wire logic [gor_pkg::QDEPTH_LOG-1:0] wrAddr; // Write entry
    input wire logic [gor_pkg::QWIDTH-1:0] wrData; // Write word
    input wire logic [gor_pkg::QDEPTH_LOG-1:0] rdAddr; // Read entry
    output logic [gor_pkg::QWIDTH-1:0] rdData_q; // Registered read word

    logic [QWIDTH-1:0] mem [2**QDEPTH_LOG]; // Entry storage

    // Store on write strobe
    always_ff @(posedge mclk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
    end

    // Read data from a register
    always_ff @(posedge mclk)
    begin
        rdData_q <= mem[rdAddr];
    end
endmodule // gor_queue_mem

// ---- hdl/gor_rate_config.sv ----
// Angular-rate offset, rate divider, low-pass, frame-sync and queue logic with APB slave
`timescale 1ns/1ps
module gor_rate_config #(
    parameter int CYC32K = gor_pkg::CYC_32K, // Cycles per 32 kHz tick
    parameter int CYC8K = gor_pkg::CYC_8K, // Cycles per 8 kHz tick
    parameter int CYC1K = gor_pkg::CYC_1K // Cycles per 1 kHz tick
) (
    input wire logic mclk, // Clock
    input wire logic rst, // Synchronous reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [gor_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [15:0] yRaw, // Raw Y rate sample
    input wire logic [15:0] zRaw, // Raw Z rate sample
    input wire logic frameSyncInput, // Frame-sync pin level
    output logic sampleStrobe, // Output sample strobe
    output logic [15:0] yRateOut, // Y rate output register
    output logic [15:0] zRateOut, // Z rate output register
    output logic frameSyncBit, // Captured frame-sync value
    output logic [2:0] frameSyncDest, // Placement of captured bit
    output logic [13:0] bandwidthHz // Current rate 3-dB bandwidth
);
    import gor_pkg::*;

    localparam logic [TICK_W-1:0] T32 = TICK_W'(CYC32K - 1); // 32 kHz reload
    localparam logic [TICK_W-1:0] T8 = TICK_W'(CYC8K - 1); // 8 kHz reload
    localparam logic [TICK_W-1:0] T1 = TICK_W'(CYC1K - 1); // 1 kHz reload

    gor_bus_type busState_q; // Access phase state
    logic [7:0] yHi_q, yLo_q, zHi_q, zLo_q; // Offset byte registers
    logic [7:0] divider_q; // Sample rate divider
    logic [7:0] cfg_q; // Filter, sync and queue configuration
    logic [1:0] bypass_q; // Filter bypass select
    logic yHiSeen_q, yLoSeen_q, zHiSeen_q, zLoSeen_q; // Byte written flags
    logic [15:0] yOfs_q, zOfs_q; // Offsets in use
    logic [TICK_W-1:0] tickCnt_q; // Internal sample timer
    logic [7:0] divCnt_q; // Divider counter
    logic [15:0] yFilt_q, zFilt_q; // Low-pass state
    logic fsPrev_q, fsLatch_q, fsArmed_q; // Frame-sync latch
    logic [QDEPTH_LOG-1:0] wrPtr_q, rdPtr_q; // Queue pointers
    logic [QDEPTH_LOG:0] qCount_q; // Queue fill level
    logic [QWIDTH-1:0] qHead; // Queue head word
    logic [2:0] lpSet, place; // Config fields
    logic tick, useDiv, strobe, access, wrAcc, rdAcc, hit, qFull, qPush, qPop;
    logic [TICK_W-1:0] tickReload; // Selected internal period
    logic [3:0] shift; // Filter weight
    logic [15:0] yIn, zIn, ySum, zSum; // Data path words
    logic [7:0] idx; // Register index
    logic [31:0] rdMux; // Read value
    logic ySyncSel, zSyncSel; // Frame-sync lands on Y or Z

    assign lpSet = cfg_q[CFG_SET_LSB +: 3];
    assign place = cfg_q[CFG_PLACE_LSB +: 3];
    assign idx = paddr[9:2];
    assign access = psel && penable && (busState_q == ST_IDLE);
    assign wrAcc = access && pwrite && hit;
    assign rdAcc = access && !pwrite && hit;

    // Internal rate choice from bypass and setting
    always_comb
    begin
        if (bypass_q[0] || bypass_q == 2'b10) tickReload = T32; // [R13]
        else if (lpSet == 3'h0 || lpSet == 3'h7) tickReload = T8; // [R13]
        else tickReload = T1; // [R13]
    end

    // Internal sample timer
    always_ff @(posedge mclk)
    begin
        if (rst || tick) tickCnt_q <= '0;
        else tickCnt_q <= tickCnt_q + 1'b1;
    end
    assign tick = tickCnt_q >= tickReload;

    // Divider only in normal filtered mode with setting 1 to 6
    assign useDiv = (bypass_q == 2'b00) && (lpSet != 3'h0) && (lpSet != 3'h7); // [R6] [R15]
    always_ff @(posedge mclk)
    begin
        if (rst) divCnt_q <= '0;
        else if (tick) divCnt_q <= (!useDiv || divCnt_q >= divider_q) ? 8'h00 : divCnt_q + 1'b1;
    end
    assign strobe = tick && (!useDiv || divCnt_q >= divider_q); // [R4] [R6]

    // Low-pass weight from setting, bypassed unless bits are zero
    always_comb
    begin
        shift = (lpSet == 3'h0 || lpSet == 3'h7) ? 4'h1 : {1'b0, lpSet};
        if (bypass_q != 2'b00) shift = 4'h0; // [R12]
    end

    // Offset-corrected raw samples
    assign ySum = yRaw + yOfs_q; // [R3]
    assign zSum = zRaw + zOfs_q; // [R3]

    // Filter state moves toward the corrected input each internal tick
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            yFilt_q <= '0;
            zFilt_q <= '0;
        end
        else if (tick)
        begin
            yFilt_q <= yFilt_q + 16'($signed(ySum - yFilt_q) >>> shift); // [R12]
            zFilt_q <= zFilt_q + 16'($signed(zSum - zFilt_q) >>> shift); // [R12]
        end
    end
    assign yIn = yFilt_q + 16'($signed(ySum - yFilt_q) >>> shift);
    assign zIn = zFilt_q + 16'($signed(zSum - zFilt_q) >>> shift);

    // Frame-sync latch: one toggle per strobe capture
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fsPrev_q <= 1'b0;
            fsLatch_q <= 1'b0;
            fsArmed_q <= 1'b1;
        end
        else
        begin
            fsPrev_q <= frameSyncInput;
            // A toggle in the strobe cycle is kept; the strobe takes the old value
            if ((fsArmed_q || strobe) && frameSyncInput != fsPrev_q)
            begin
                fsLatch_q <= ~fsLatch_q; // [R11]
                fsArmed_q <= 1'b0; // [R11]
            end
            else if (strobe) fsArmed_q <= 1'b1; // [R11]
        end
    end

    assign ySyncSel = place == PLACE_Y; // [R10]
    assign zSyncSel = place == PLACE_Z; // [R10]

    // Output registers update on the sample strobe
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            yRateOut <= '0;
            zRateOut <= '0;
            frameSyncBit <= 1'b0;
            frameSyncDest <= PLACE_OFF;
            sampleStrobe <= 1'b0;
        end
        else
        begin
            sampleStrobe <= strobe; // [R5]
            if (strobe)
            begin
                yRateOut <= {yIn[15:1], ySyncSel ? fsLatch_q : yIn[0]}; // [R5] [R10]
                zRateOut <= {zIn[15:1], zSyncSel ? fsLatch_q : zIn[0]}; // [R5] [R10]
                frameSyncBit <= (place == PLACE_OFF) ? 1'b0 : fsLatch_q; // [R11]
                frameSyncDest <= place; // [R10]
            end
        end
    end

    // Bandwidth figure for the current mode
    always_ff @(posedge mclk)
    begin
        if (rst) bandwidthHz <= BW_SET[0];
        else if (bypass_q[0]) bandwidthHz <= BW_BYP0; // [R14]
        else if (bypass_q[1]) bandwidthHz <= BW_BYP1; // [R14]
        else bandwidthHz <= BW_SET[lpSet]; // [R14]
    end

    // Queue push on strobe, policy decides full behaviour; pop on data read
    assign qFull = qCount_q[QDEPTH_LOG];
    assign qPop = rdAcc && idx == IDX_QUEUE_DATA && qCount_q != '0;
    assign qPush = strobe && !(qFull && cfg_q[CFG_POLICY_BIT]); // [R5] [R8]
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            qCount_q <= '0;
        end
        else
        begin
            if (qPush) wrPtr_q <= wrPtr_q + 1'b1;
            if (qPop || (qPush && qFull)) rdPtr_q <= rdPtr_q + 1'b1; // [R9]
            if (qPush && !qFull && !qPop) qCount_q <= qCount_q + 1'b1;
            else if (qPop && !qPush) qCount_q <= qCount_q - 1'b1;
        end
    end

    gor_queue_mem uQueue (
        .mclk(mclk),
        .wrEn(qPush),
        .wrAddr(wrPtr_q),
        .wrData({yIn, zIn}),
        .rdAddr(rdPtr_q),
        .rdData_q(qHead)
    );

    // Register writes from the bus
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            yHi_q <= BYTE_RESET;
            yLo_q <= BYTE_RESET;
            zHi_q <= BYTE_RESET;
            zLo_q <= BYTE_RESET;
            divider_q <= BYTE_RESET;
            cfg_q <= CFG_RESET; // [R7]
            bypass_q <= 2'b00;
        end
        else if (wrAcc)
        begin
            unique case (idx)
                IDX_Y_OFS_HI: yHi_q <= pwdata[7:0]; // [R1]
                IDX_Y_OFS_LO: yLo_q <= pwdata[7:0]; // [R1]
                IDX_Z_OFS_HI: zHi_q <= pwdata[7:0]; // [R2]
                IDX_Z_OFS_LO: zLo_q <= pwdata[7:0]; // [R2]
                IDX_DIVIDER: divider_q <= pwdata[7:0]; // [R4]
                IDX_FSQ_CFG: cfg_q <= pwdata[7:0];
                IDX_RATE_CFG: bypass_q <= pwdata[RCFG_BYP_LSB +: 2]; // [R15]
                default: ;
            endcase
        end
    end

    // Offset takes effect once both of its bytes are written
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            {yHiSeen_q, yLoSeen_q, zHiSeen_q, zLoSeen_q} <= 4'h0;
            yOfs_q <= '0;
            zOfs_q <= '0;
        end
        else
        begin
            if (yHiSeen_q && yLoSeen_q)
            begin
                yOfs_q <= {yHi_q, yLo_q}; // [R16]
                {yHiSeen_q, yLoSeen_q} <= 2'b00;
            end
            else if (zHiSeen_q && zLoSeen_q)
            begin
                zOfs_q <= {zHi_q, zLo_q}; // [R16]
                {zHiSeen_q, zLoSeen_q} <= 2'b00;
            end
            // A byte written in the apply cycle stays marked, so the set wins
            if (wrAcc)
            begin
                if (idx == IDX_Y_OFS_HI) yHiSeen_q <= 1'b1; // [R16]
                if (idx == IDX_Y_OFS_LO) yLoSeen_q <= 1'b1; // [R16]
                if (idx == IDX_Z_OFS_HI) zHiSeen_q <= 1'b1; // [R16]
                if (idx == IDX_Z_OFS_LO) zLoSeen_q <= 1'b1; // [R16]
            end
        end
    end

    // Address decode and read mux
    always_comb
    begin
        hit = 1'b1;
        rdMux = 32'h0;
        unique case (idx)
            IDX_Y_OFS_HI: rdMux[7:0] = yHi_q;
            IDX_Y_OFS_LO: rdMux[7:0] = yLo_q;
            IDX_Z_OFS_HI: rdMux[7:0] = zHi_q;
            IDX_Z_OFS_LO: rdMux[7:0] = zLo_q;
            IDX_DIVIDER: rdMux[7:0] = divider_q;
            IDX_FSQ_CFG: rdMux[7:0] = cfg_q;
            IDX_RATE_CFG: rdMux[1:0] = bypass_q;
            IDX_Y_OUT: rdMux[15:0] = yRateOut;
            IDX_Z_OUT: rdMux[15:0] = zRateOut;
            IDX_QUEUE_DATA: rdMux = qHead;
            IDX_QUEUE_STAT: rdMux[QDEPTH_LOG:0] = qCount_q;
            IDX_BANDWIDTH: rdMux[13:0] = bandwidthHz;
            default: hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00) hit = 1'b0;
    end

    // Answer one cycle after the access phase starts
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            busState_q <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            unique case (busState_q)
                ST_IDLE:
                begin
                    if (psel && penable)
                    begin
                        busState_q <= ST_ANSWER;
                        pready <= 1'b1;
                        pslverr <= !hit;
                        prdata <= (pwrite || !hit) ? 32'h0 : rdMux;
                    end
                end
                ST_ANSWER:
                begin
                    busState_q <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end
endmodule // gor_rate_config

// ---- dv/gor_rate_config_sva.sv ----
// Concurrent checks on the rate block's register port and sample outputs
`timescale 1ns/1ps
module gor_rate_config_sva
    import gor_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic rst, // Reset, high
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic sampleStrobe, // Output strobe
    input wire logic [15:0] yRateOut, // Y output
    input wire logic [15:0] zRateOut, // Z output
    input wire logic frameSyncBit, // Captured sync value
    input wire logic [2:0] frameSyncDest, // Sync placement
    input wire logic [13:0] bandwidthHz // Bandwidth figure
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // First access cycle, not yet answered
    sequence s_taken;
        psel && penable && !pready;
    endsequence
    a_ready_prompt: assert property (s_taken |=> pready)
        else $error("ready late after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    a_reset_bw: assert property (disable iff (1'b0) rst |=> bandwidthHz == 14'h0fa)
        else $error("bandwidth after reset wrong");
    a_strobe_gap: assert property (sampleStrobe |=> !sampleStrobe [*8])
        else $error("strobes too close");
    a_y_on_strobe: assert property ($changed(yRateOut) |-> ##[0:1] sampleStrobe)
        else $error("Y output moved without strobe");
    a_z_on_strobe: assert property ($changed(zRateOut) |-> ##[0:1] sampleStrobe)
        else $error("Z output moved without strobe");
    a_sync_held: assert property ($changed(frameSyncBit) |-> ##[0:1] sampleStrobe)
        else $error("sync bit moved without strobe");
    a_sync_off: assert property (frameSyncDest == PLACE_OFF |-> !frameSyncBit)
        else $error("sync bit set while disabled");
    a_sync_in_y: assert property (frameSyncDest == PLACE_Y |-> yRateOut[0] == frameSyncBit)
        else $error("sync bit missing from Y");
    a_sync_in_z: assert property (frameSyncDest == PLACE_Z |-> zRateOut[0] == frameSyncBit)
        else $error("sync bit missing from Z");
endmodule // gor_rate_config_sva

bind gor_rate_config gor_rate_config_sva u_sva (.mclk, .rst, .psel, .penable, .prdata,
    .pready, .pslverr, .sampleStrobe, .yRateOut, .zRateOut, .frameSyncBit,
    .frameSyncDest, .bandwidthHz);

// ---- dv/gor_host_model.sv ----
// APB host model that drives the rate block's register port
`timescale 1ns/1ps
module gor_host_model (
    input wire logic mclk, // Clock
    output logic psel, // Select
    output logic penable, // Enable
    output logic pwrite, // Direction
    output logic [gor_pkg::ADDR_W-1:0] paddr, // Byte address
    output logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr // Error
);
    import gor_pkg::*;
    // Bus idle at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
    end
    // One transfer: setup, then access held until ready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
        begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Configuration write, top bit always cleared by software
    task automatic cfg(input logic [7:0] v);
        logic [31:0] r;
        logic e;
        xfer(1'b1, IDX_FSQ_CFG, {1'b0, v[6:0]}, r, e);
    endtask
endmodule // gor_host_model

// ---- dv/testbench.sv ----
// Self-checking bench for the rate offset, divider, filter, sync and queue block
`timescale 1ns/1ps
module testbench;
    import gor_pkg::*;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr; // Clock, reset, bus
    logic [ADDR_W-1:0] paddr; // Byte address
    logic [31:0] pwdata, prdata, r; // Bus data and last read
    logic [15:0] yRaw, zRaw, offY, offZ; // Raw samples and expected offsets
    logic frameSyncInput, sampleStrobe, frameSyncBit, e, b; // Sync pin, strobe, flags
    logic [15:0] yRateOut, zRateOut; // Outputs
    logic [2:0] frameSyncDest; // Placement
    logic [13:0] bandwidthHz; // Bandwidth
    int mismatches, cmpCount, n, ex; // Counters and gap figures
    // Expected bandwidths: settings 0..7, then bypass codes 1..3
    logic [31:0] bwTab [11] = '{32'hfa, 32'hb0, 32'h5c, 32'h29, 32'h14, 32'ha, 32'h5,
                                32'hcd1, 32'h1fed, 32'hcd1, 32'h1fed};
    gor_host_model host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    gor_rate_config #(.CYC32K(20), .CYC8K(40), .CYC1K(80)) dut (.mclk(mclk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .yRaw(yRaw), .zRaw(zRaw),
        .frameSyncInput(frameSyncInput), .sampleStrobe(sampleStrobe),
        .yRateOut(yRateOut), .zRateOut(zRateOut), .frameSyncBit(frameSyncBit),
        .frameSyncDest(frameSyncDest), .bandwidthHz(bandwidthHz));
    // 200 MHz clock
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        logic y;
        host.xfer(1'b1, idx, d, x, y);
    endtask
    task automatic rd(input logic [7:0] idx);
        host.xfer(1'b0, idx, 8'h00, r, e);
    endtask
    // Wait for k output strobes
    task automatic waitStb(input int k);
        repeat (k)
        begin
            @(posedge mclk);
            while (sampleStrobe !== 1'b1)
            begin
                @(posedge mclk);
            end
        end
    endtask
    task automatic testDone;
        $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog against a hang
    initial
    begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        testDone;
    end
    // Main sequence
    initial
    begin
        rst = 1'b1;
        yRaw = 16'h0;
        zRaw = 16'h0;
        frameSyncInput = 1'b0;
        mismatches = 0;
        cmpCount = 0;
        offY = 16'hb0b3;
        offZ = 16'hb2bd;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(IDX_FSQ_CFG);
        chk(r, 32'h80);
        rd(IDX_Y_OFS_HI);
        chk(r, 32'h0);
        chk({18'h0, bandwidthHz}, 32'hfa);
        rd(8'h30);
        chk({31'h0, e}, 32'h1);
        $display("reset test done");
        for (int i = 'h15; i <= 'h19; i++)
        begin
            wr(8'(i), 8'(i) ^ 8'ha5);
            rd(8'(i));
            chk(r, {24'h0, 8'(i) ^ 8'ha5});
        end
        host.cfg(8'h00);
        wr(IDX_RATE_CFG, 8'h01);
        yRaw <= 16'h1234;
        zRaw <= 16'h0100;
        waitStb(3);
        chk({16'h0, yRateOut}, {16'h0, yRaw + offY});
        chk({16'h0, zRateOut}, {16'h0, zRaw + offZ});
        wr(IDX_Y_OFS_HI, 8'h01);
        waitStb(3);
        chk({16'h0, yRateOut}, {16'h0, yRaw + offY});
        wr(IDX_Y_OFS_LO, 8'h02);
        offY = 16'h0102;
        waitStb(3);
        chk({16'h0, yRateOut}, {16'h0, yRaw + offY});
        $display("register and offset test done");
        wr(IDX_DIVIDER, 8'h02);
        for (int i = 0; i < 11; i++)
        begin
            wr(IDX_RATE_CFG, (i < 8) ? 8'h00 : 8'(i - 7));
            host.cfg((i < 8) ? 8'(i) : 8'h03);
            waitStb(2);
            n = 0;
            do
            begin
                @(posedge mclk);
                n++;
            end
            while (sampleStrobe !== 1'b1);
            ex = (i > 7) ? 20 : (i == 0 || i == 7) ? 40 : 240;
            chk(32'(n), 32'(ex));
            chk({18'h0, bandwidthHz}, bwTab[i]);
        end
        $display("rate and bandwidth test done");
        for (int c = 0; c < 8; c++)
        begin
            host.cfg(8'(c << 3));
            waitStb(2);
            chk({29'h0, frameSyncDest}, 32'(c));
        end
        host.cfg(8'h18);
        waitStb(2);
        b = frameSyncBit;
        frameSyncInput <= ~frameSyncInput;
        @(posedge mclk);
        frameSyncInput <= ~frameSyncInput;
        waitStb(2);
        chk({31'h0, frameSyncBit}, {31'h0, ~b});
        chk({31'h0, yRateOut[0]}, {31'h0, ~b});
        $display("frame sync test done");
        host.cfg(8'h00);
        yRaw <= 16'h1111;
        waitStb(9);
        host.cfg(8'h40);
        rd(IDX_QUEUE_STAT);
        chk(r, 32'h8);
        yRaw <= 16'h2222;
        zRaw <= 16'h3333;
        waitStb(3);
        rd(IDX_QUEUE_DATA);
        chk({16'h0, r[31:16]}, {16'h0, 16'h1111 + offY});
        chk({16'h0, r[15:0]}, {16'h0, 16'h0100 + offZ});
        host.cfg(8'h00);
        waitStb(9);
        rd(IDX_QUEUE_DATA);
        chk({16'h0, r[31:16]}, {16'h0, 16'h2222 + offY});
        chk({16'h0, r[15:0]}, {16'h0, 16'h3333 + offZ});
        $display("queue test done");
        testDone;
    end
endmodule // testbench
